/* wkt_pkg.sv */
// Purpose: Constants and types for the 32-bit wake-up timer.
// Assumes: APB slave, 32-bit data, 16-bit registers in low lanes.
// Notes:   All register offsets are full byte addresses.
package wkt_pkg;
    // Register byte addresses
    localparam logic [31:0] ADR_CNT_LO  = 32'h4000_2500;
    localparam logic [31:0] ADR_CNT_HI  = 32'h4000_2504;
    localparam logic [31:0] ADR_CTL     = 32'h4000_2508;
    localparam logic [31:0] ADR_INC     = 32'h4000_250c;
    localparam logic [31:0] ADR_B_LO    = 32'h4000_2510;
    localparam logic [31:0] ADR_B_HI    = 32'h4000_2514;
    localparam logic [31:0] ADR_C_LO    = 32'h4000_2518;
    localparam logic [31:0] ADR_C_HI    = 32'h4000_251c;
    localparam logic [31:0] ADR_D_LO    = 32'h4000_2520;
    localparam logic [31:0] ADR_D_HI    = 32'h4000_2524;
    localparam logic [31:0] ADR_IEN     = 32'h4000_2528;
    localparam logic [31:0] ADR_STA     = 32'h4000_252c;
    localparam logic [31:0] ADR_CLR     = 32'h4000_2530;
    localparam logic [31:0] ADR_A_LO    = 32'h4000_253c;
    localparam logic [31:0] ADR_A_HI    = 32'h4000_2540;
    // Control field positions
    localparam int CTL_CLK_LSB = 9;
    localparam int CTL_WAKE_SIGNAL_ENABLE    = 8;
    localparam int CTL_EN      = 7;
    localparam int CTL_FREE    = 6;
    localparam int CTL_FREEZE  = 3;
    localparam int CTL_PRE_LSB = 0;
    // Status field position, event source count and interval shift
    localparam int STA_CLR_BUSY = 7;
    localparam int NUM_SRC      = 5;
    localparam int INC_SHIFT    = 5;
    // Reset values and full-scale count
    localparam logic [15:0] RST_CTL = 16'h0040;
    localparam logic [11:0] RST_INC = 12'h0c8;
    localparam logic [31:0] RST_A   = 32'h0000_1900;
    localparam logic [31:0] RST_B   = 32'h0000_1fff;
    localparam logic [31:0] RST_C   = 32'h0000_2fff;
    localparam logic [31:0] RST_D   = 32'h0000_3fff;
    localparam logic [31:0] FULL    = 32'hffff_ffff;
    // Prescale factors
    localparam logic [15:0] DIV_PCLK0 = 16'h0004;
    localparam logic [15:0] DIV_1     = 16'h0001;
    localparam logic [15:0] DIV_16    = 16'h0010;
    localparam logic [15:0] DIV_256   = 16'h0100;
    localparam logic [15:0] DIV_32K   = 16'h8000;
    // Source clears take effect after this many source edges
    localparam logic [1:0]  CLR_EDGES = 2'h2;
    // Clock source selection
    typedef enum logic [1:0] {
        WKT_SRC_PCLK = 2'b00,
        WKT_SRC_XTAL = 2'b01,
        WKT_SRC_OSC  = 2'b10,
        WKT_SRC_EXT  = 2'b11
    } wkt_src_t;
    // Decoded control fields
    typedef struct packed {
        wkt_src_t   clk_sel;
        logic       wake_signal_enable;
        logic       en;
        logic       free;
        logic       freeze;
        logic [1:0] pre;
    } wkt_ctl_t;
endpackage : wkt_pkg

/* wkt_timer.sv */
// Purpose: 32-bit wake-up timer with four compare points, APB slave.
// Assumes: Slow clock inputs are already synchronous to clk_sys.
// Notes:   Slave answers with no wait states; unmapped gives pslverr.
`timescale 1ns/1ns
module wkt_timer
    import wkt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Count clock sources
    input  wire logic        low_freq_crystal,
    input  wire logic        low_freq_oscillator,
    input  wire logic        external_clock_input,
    // Events out
    output logic             irq_o,
    output logic             wake_o
);
    // Prescale factor for a source and code
    function automatic logic [15:0] pre_div(wkt_src_t s, logic [1:0] p);
        case (p)
            2'b00:   pre_div = (s == WKT_SRC_PCLK) ? DIV_PCLK0 : DIV_1;
            2'b01:   pre_div = DIV_16;
            2'b10:   pre_div = DIV_256;
            default: pre_div = DIV_32K;
        endcase
    endfunction : pre_div

    logic [15:0]         ctl_q;
    wkt_ctl_t            ctl;
    logic [11:0]         inc_q;
    logic [31:0]         cmp_a_q;
    logic [31:0]         cmp_b_q;
    logic [31:0]         cmp_c_q;
    logic [31:0]         cmp_d_q;
    logic [NUM_SRC-1:0]  ien_q;
    logic [NUM_SRC-1:0]  sta_q;
    logic [NUM_SRC-1:0]  clr_pend_q;
    logic [1:0]          clr_cnt_q;
    logic [31:0]         cnt_q;
    logic [31:0]         cnt_d;
    logic [15:0]         hi_latch_q;
    logic                frozen_q;
    logic [14:0]         pre_cnt_q;
    logic [2:0]          src_prev_q;
    logic                src_tick;
    logic                tick;
    logic [NUM_SRC-1:0]  ev;
    logic [32:0]         a_sum;
    logic [31:0]         a_next;
    logic                wake_q;
    logic [31:0]         rd_d;
    logic                setup;
    logic                wr;
    logic                hit;
    logic                clr_fire;

    assign ctl = '{clk_sel: wkt_src_t'(ctl_q[CTL_CLK_LSB +: 2]),
                   wake_signal_enable:    ctl_q[CTL_WAKE_SIGNAL_ENABLE],
                   en:      ctl_q[CTL_EN],
                   free:    ctl_q[CTL_FREE],
                   freeze:  ctl_q[CTL_FREEZE],
                   pre:     ctl_q[CTL_PRE_LSB +: 2]};

    // Bus strobes; no wait states so access completes in one cycle
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Source edge detect; all slow clocks live in the clk_sys domain
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            src_prev_q <= 3'h0;
        end else begin
            src_prev_q <= {external_clock_input, low_freq_oscillator,
                           low_freq_crystal};
        end
    end

    // One tick per rising source edge, every cycle for peripheral clock
    always_comb begin
        case (ctl.clk_sel)
            WKT_SRC_PCLK: src_tick = 1'b1;
            WKT_SRC_XTAL: src_tick = low_freq_crystal & ~src_prev_q[0];
            WKT_SRC_OSC:  src_tick = low_freq_oscillator & ~src_prev_q[1];
            WKT_SRC_EXT:  src_tick = external_clock_input & ~src_prev_q[2];
            default:      src_tick = 1'b0;
        endcase
    end

    // Prescaler; held at zero while stopped so first tick is a full one
    assign tick = ctl.en & src_tick &
        ({1'b0, pre_cnt_q} == pre_div(ctl.clk_sel, ctl.pre) - 16'h0001);
    always_ff @(posedge clk_sys) begin
        if (srst || !ctl.en) begin
            pre_cnt_q <= 15'h0000;
        end else if (tick) begin
            pre_cnt_q <= 15'h0000;
        end else if (src_tick) begin
            pre_cnt_q <= pre_cnt_q + 15'h0001;
        end
    end

    // Next count: wraps at full scale or at the period limit
    always_comb begin
        if (!ctl.free && cnt_q == cmp_d_q) begin
            cnt_d = 32'h0000_0000;
        end else begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    // Counter; clearing the enable stops and zeroes it
    always_ff @(posedge clk_sys) begin
        if (srst || !ctl.en) begin
            cnt_q <= 32'h0000_0000;
        end else if (tick) begin
            cnt_q <= cnt_d;
        end
    end

    // Match events, judged on the value the counter is moving to
    assign ev[0] = tick & (cnt_d == cmp_a_q);
    assign ev[1] = tick & (cnt_d == cmp_b_q);
    assign ev[2] = tick & (cnt_d == cmp_c_q);
    assign ev[3] = tick & (cnt_d == cmp_d_q);
    assign ev[4] = tick & ctl.free & (cnt_d == FULL);

    // Next auto compare; 33-bit sum exposes the overflow
    assign a_sum = {1'b0, cmp_a_q} + {16'h0000, inc_q, 5'h00};
    always_comb begin
        if (!ctl.free && a_sum > {1'b0, cmp_d_q}) begin
            a_next = 32'(a_sum - {1'b0, cmp_d_q});
        end else begin
            a_next = a_sum[31:0];
        end
    end

    // Interval and automatic compare; software cannot write A
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            inc_q   <= RST_INC;
            cmp_a_q <= RST_A;
        end else if (wr && paddr == ADR_INC) begin
            inc_q   <= pwdata[11:0];
            cmp_a_q <= {15'h0000, pwdata[11:0], 5'h00};
        end else if (ev[0]) begin
            cmp_a_q <= a_next;
        end
    end

    // Control, mask and software compares
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_q   <= RST_CTL;
            ien_q   <= '0;
            cmp_b_q <= RST_B;
            cmp_c_q <= RST_C;
            cmp_d_q <= RST_D;
        end else if (wr) begin
            case (paddr)
                ADR_CTL:  ctl_q <= pwdata[15:0] & 16'h07cb;
                ADR_IEN:  ien_q <= pwdata[NUM_SRC-1:0];
                ADR_B_LO: cmp_b_q[15:0]  <= pwdata[15:0];
                ADR_B_HI: cmp_b_q[31:16] <= pwdata[15:0];
                ADR_C_LO: cmp_c_q[15:0]  <= pwdata[15:0];
                ADR_C_HI: cmp_c_q[31:16] <= pwdata[15:0];
                ADR_D_LO: cmp_d_q[15:0]  <= pwdata[15:0];
                ADR_D_HI: cmp_d_q[31:16] <= pwdata[15:0];
                default:  ;
            endcase
        end
    end

    // Clear waits two source edges, as the slow domain would need
    assign clr_fire = (clr_pend_q != '0) & src_tick &
                      (clr_cnt_q == CLR_EDGES - 2'h1);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clr_pend_q <= '0;
            clr_cnt_q  <= 2'h0;
        end else if (wr && paddr == ADR_CLR) begin
            clr_pend_q <= clr_pend_q | pwdata[NUM_SRC-1:0];
            clr_cnt_q  <= 2'h0;
        end else if (clr_fire) begin
            clr_pend_q <= '0;
            clr_cnt_q  <= 2'h0;
        end else if (clr_pend_q != '0 && src_tick) begin
            clr_cnt_q  <= clr_cnt_q + 2'h1;
        end
    end

    // Sticky status; a new event beats a clear landing the same cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sta_q <= '0;
        end else if (clr_fire) begin
            sta_q <= (sta_q & ~clr_pend_q) | ev;
        end else begin
            sta_q <= sta_q | ev;
        end
    end

    // Interrupt line is the masked status
    assign irq_o = |(sta_q & ien_q);

    // Wake pulse for enabled compare matches only, not full scale
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= ctl.wake_signal_enable & |(ev[3:0] & ien_q[3:0]);
        end
    end
    assign wake_o = wake_q;

    // Freeze latch, taken at the setup of a low-half read
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frozen_q   <= 1'b0;
            hi_latch_q <= 16'h0000;
        end else if (setup && !pwrite && paddr == ADR_CNT_LO
                     && ctl.freeze) begin
            frozen_q   <= 1'b1;
            hi_latch_q <= cnt_q[31:16];
        end else if (setup && !pwrite && paddr == ADR_CNT_HI) begin
            frozen_q   <= 1'b0;
        end
    end

    // Read mux; reserved bits read as zero
    always_comb begin
        hit  = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            ADR_CNT_LO: rd_d[15:0] = cnt_q[15:0];
            ADR_CNT_HI: rd_d[15:0] = frozen_q ? hi_latch_q
                                              : cnt_q[31:16];
            ADR_CTL:    rd_d[15:0] = ctl_q;
            ADR_INC:    rd_d[11:0] = inc_q;
            ADR_B_LO:   rd_d[15:0] = cmp_b_q[15:0];
            ADR_B_HI:   rd_d[15:0] = cmp_b_q[31:16];
            ADR_C_LO:   rd_d[15:0] = cmp_c_q[15:0];
            ADR_C_HI:   rd_d[15:0] = cmp_c_q[31:16];
            ADR_D_LO:   rd_d[15:0] = cmp_d_q[15:0];
            ADR_D_HI:   rd_d[15:0] = cmp_d_q[31:16];
            ADR_IEN:    rd_d[NUM_SRC-1:0] = ien_q;
            ADR_STA: begin
                rd_d[NUM_SRC-1:0]   = sta_q;
                rd_d[STA_CLR_BUSY]  = clr_pend_q != '0;
            end
            ADR_CLR:    rd_d = 32'h0000_0000;
            ADR_A_LO:   rd_d[15:0] = cmp_a_q[15:0];
            ADR_A_HI:   rd_d[15:0] = cmp_a_q[31:16];
            default:    hit = 1'b0;
        endcase
    end

    // Read data registered at setup, stable through the access phase
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_count_up;
        tick && cnt_d != 32'h0 |=> cnt_q == $past(cnt_q) + 32'h1;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("Counter did not step up on a tick");

    property p_stop_zero;
        !ctl.en |=> cnt_q == 32'h0000_0000;
    endproperty
    a_stop_zero: assert property (p_stop_zero)
        else $error("Counter not zero while stopped");

    property p_free_wrap;
        ctl.free && tick && cnt_q == FULL |=> cnt_q == 32'h0;
    endproperty
    a_free_wrap: assert property (p_free_wrap)
        else $error("Free-running count did not wrap");

    property p_period_wrap;
        !ctl.free && tick && cnt_q == cmp_d_q |=> cnt_q == 32'h0;
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("Periodic count did not restart at limit");

    property p_pclk_div4;
        disable iff (srst || !ctl.en)
        ctl.clk_sel == WKT_SRC_PCLK && ctl.pre == 2'b00 && tick
        |=> !tick [*3] ##1 tick;
    endproperty
    a_pclk_div4: assert property (p_pclk_div4)
        else $error("Peripheral clock code 00 not divided by 4");

    property p_inc_load;
        wr && paddr == ADR_INC
        |=> cmp_a_q == {15'h0000, $past(pwdata[11:0]), 5'h00};
    endproperty
    a_inc_load: assert property (p_inc_load)
        else $error("Interval write did not load auto compare");

    property p_auto_free;
        ev[0] && ctl.free && !(wr && paddr == ADR_INC)
        |=> cmp_a_q == $past(cmp_a_q) + {15'h0, $past(inc_q), 5'h0};
    endproperty
    a_auto_free: assert property (p_auto_free)
        else $error("Auto compare did not advance by interval");

    property p_event_sets;
        ev[1] |=> sta_q[1] ##1 (sta_q[1] || $past(clr_fire));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("Match did not set status");

    property p_clear_takes;
        clr_fire |=> (sta_q & $past(clr_pend_q) & ~$past(ev)) == '0;
    endproperty
    a_clear_takes: assert property (p_clear_takes)
        else $error("Clear did not take effect");

    property p_wake;
        ctl.wake_signal_enable && ev[1] && ien_q[1] |=> wake_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Enabled match gave no wake pulse");

    property p_freeze;
        setup && !pwrite && paddr == ADR_CNT_LO && ctl.freeze
        |=> frozen_q && hi_latch_q == $past(cnt_q[31:16]);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("Low read did not freeze high half");
endmodule : wkt_timer

/* wakeup_timer_32bit_test.sv */
// Purpose: Self-checking bench for the wake-up timer over its APB port.
// Assumes: Slave answers without wait states; clock inputs driven in step.
// Notes:   Slow sources are pulsed by the bench so tick counts are exact.
`timescale 1ns/1ns
module wakeup_timer_32bit_test
    import wkt_pkg::*;
;
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

    logic        clk_sys = 1'b0;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  lines;
    logic        irq_o;
    logic        wake_o;
    logic [31:0] q;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic        err_q;
    int          mismatches = 0;
    int          n_compared = 0;
    int          wake_n = 0;
    int          n;
    int          v;
    logic [31:0] ra [14] = '{ADR_CNT_LO, ADR_CNT_HI, ADR_CTL, ADR_INC,
        ADR_B_LO, ADR_B_HI, ADR_C_LO, ADR_C_HI, ADR_D_LO, ADR_D_HI,
        ADR_IEN, ADR_STA, ADR_A_LO, ADR_A_HI};
    logic [15:0] rv [14] = '{16'h0000, 16'h0000, 16'h0040, 16'h00c8,
        16'h1fff, 16'h0000, 16'h2fff, 16'h0000, 16'h3fff, 16'h0000,
        16'h0000, 16'h0000, 16'h1900, 16'h0000};
    logic [15:0] dv [4] = '{DIV_PCLK0, DIV_16, DIV_256, DIV_32K};

    wkt_timer u_wkt_timer (
        .clk_sys              (clk_sys),
        .srst                 (srst),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .low_freq_crystal     (lines[0]),
        .low_freq_oscillator  (lines[1]),
        .external_clock_input (lines[2]),
        .irq_o                (irq_o),
        .wake_o               (wake_o)
    );

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    // Wake is a one-cycle pulse, so count every high cycle
    always @(posedge clk_sys) begin
        if (wake_o === 1'b1) wake_n++;
    end

    // Control word built from fields, reserved bits zero
    function automatic logic [15:0] cw(input logic [1:0] s, input logic wu,
        input logic en, input logic fr, input logic fz,
        input logic [1:0] p);
        return {5'h00, s, wu, en, fr, 2'b00, fz, 1'b0, p};
    endfunction : cw

    // Next automatic compare after a match
    function automatic logic [31:0] exp_adv(input logic [31:0] old,
        input logic [11:0] inc, input logic [31:0] per, input logic fr);
        logic [31:0] nx;
        nx = old + ({20'h0_0000, inc} << 5);
        if (!fr && nx > per) nx = nx - per;
        return nx;
    endfunction : exp_adv

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [31:0] ad,
        input logic [31:0] d, output logic [31:0] rq);
        int g;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        g = 0;
        do begin
            @(posedge clk_sys);
            g++;
        end while (pready !== 1'b1 && g < 100);
        if (g >= 100) mismatches++;
        rq      = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        logic [31:0] t;
        apb(1'b1, ad, d, t);
    endtask : wr

    task automatic chk(input string nm, input logic [31:0] ad,
        input logic [15:0] ex);
        logic [31:0] t;
        apb(1'b0, ad, 32'h0000_0000, t);
        `CHK(nm, {16'h0000, ex}, t)
    endtask : chk

    // Pulse source s n times; the other lines toggle faster as decoys.
    // The line is lowered first so a line left high still gives an edge;
    // the last edge is seen at the first clock of the next bus transfer.
    task automatic pulse(input logic [1:0] s, input int cnt);
        logic [2:0] m;
        m = 3'b001 << (s - 2'd1);
        repeat (cnt) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge clk_sys);
                lines <= ((lines ^ ~m) & ~m) | ((k == 2) ? m : 3'b000);
            end
        end
    endtask : pulse

    task automatic final_report;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Cuts a hang short; the tests need about 41000 cycles
    initial begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end

    // Main sequence
    initial begin
        void'($urandom(71983));
        srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0000_0000; pwdata = 32'h0000_0000; lines = 3'b000;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 14; i++) chk("reset", ra[i], rv[i]);
        apb(1'b0, 32'h4000_2534, 32'h0000_0000, q);
        `CHK("unmapped err", 1'b1, err_q)
        `CHK("unmapped data", 32'h0000_0000, q)
        wr(ADR_A_LO, 32'h0000_1234);
        chk("ro auto", ADR_A_LO, 16'h1900);
        r = $urandom;
        wr(ADR_C_HI, r);
        chk("c high", ADR_C_HI, r[15:0]);
        wr(ADR_C_HI, 32'h0000_0000);
        // Periodic run on the external pin, period limit 40
        wr(ADR_B_LO, 32'h0000_0003);
        wr(ADR_C_LO, 32'h0000_0004);
        wr(ADR_D_LO, 32'h0000_0028);
        wr(ADR_INC, 32'h0000_0001);
        chk("auto load", ADR_A_LO, 16'h0020);
        wr(ADR_IEN, 32'h0000_0002);
        wr(ADR_CTL, cw(2'd3, 1'b1, 1'b0, 1'b0, 1'b0, 2'd0));
        wr(ADR_CTL, cw(2'd3, 1'b1, 1'b1, 1'b0, 1'b0, 2'd0));
        pulse(2'd3, 3);
        chk("count", ADR_CNT_LO, 16'h0003);
        chk("status b", ADR_STA, 16'h0002);
        `CHK("irq on", 1'b1, irq_o)
        `CHK("wake", 1, wake_n)
        pulse(2'd3, 1);
        chk("status c", ADR_STA, 16'h0006);
        wr(ADR_CLR, 32'h0000_0002);
        chk("clr pend", ADR_STA, 16'h0086);
        pulse(2'd3, 1);
        chk("clr one", ADR_STA, 16'h0086);
        pulse(2'd3, 1);
        chk("clr two", ADR_STA, 16'h0004);
        `CHK("irq masked", 1'b0, irq_o)
        `CHK("wake masked", 1, wake_n)
        pulse(2'd3, 26);
        chk("auto wrap", ADR_A_LO,
            16'(exp_adv(32'd32, 12'd1, 32'd40, 1'b0)));
        pulse(2'd3, 8);
        chk("period hit", ADR_STA, 16'h000d);
        pulse(2'd3, 1);
        chk("restart", ADR_CNT_LO, 16'h0000);
        pulse(2'd3, 2);
        wr(ADR_CTL, cw(2'd3, 1'b1, 1'b0, 1'b0, 1'b0, 2'd0));
        chk("stop zero", ADR_CNT_LO, 16'h0000);
        // Each slow source counts only its own edges
        for (int s = 1; s < 4; s++) begin
            wr(ADR_CTL, cw(s[1:0], 1'b0, 1'b0, 1'b1, 1'b0, 2'd0));
            wr(ADR_CTL, cw(s[1:0], 1'b0, 1'b1, 1'b1, 1'b0, 2'd0));
            n = 1 + ($urandom % 40);
            pulse(s[1:0], n);
            chk("source", ADR_CNT_LO, n[15:0]);
        end
        // Free-running auto compare advance with a random interval
        wr(ADR_CTL, cw(2'd3, 1'b0, 1'b0, 1'b1, 1'b0, 2'd0));
        v = 1 + ($urandom % 15);
        wr(ADR_INC, v);
        wr(ADR_CTL, cw(2'd3, 1'b0, 1'b1, 1'b1, 1'b0, 2'd0));
        pulse(2'd3, v * 32);
        chk("auto adv", ADR_A_LO,
            16'(exp_adv(v * 32, 12'(v), 32'd0, 1'b1)));
        // Peripheral clock: count advance over a fixed window per prescale
        for (int p = 0; p < 4; p++) begin
            n = (p == 3) ? 1 : 25;
            wr(ADR_CTL, cw(2'd0, 1'b0, 1'b0, 1'b1, 1'b0, p[1:0]));
            wr(ADR_CTL, cw(2'd0, 1'b0, 1'b1, 1'b1, 1'b0, p[1:0]));
            apb(1'b0, ADR_CNT_LO, 32'h0000_0000, a);
            repeat (n * dv[p] - 3) @(posedge clk_sys);
            apb(1'b0, ADR_CNT_LO, 32'h0000_0000, b);
            `CHK("prescale", n, b - a)
        end
        // Freeze: high half read after a low read
        wr(ADR_CTL, cw(2'd0, 1'b0, 1'b0, 1'b1, 1'b1, 2'd0));
        wr(ADR_CTL, cw(2'd0, 1'b0, 1'b1, 1'b1, 1'b1, 2'd0));
        apb(1'b0, ADR_CNT_LO, 32'h0000_0000, a);
        chk("frozen high", ADR_CNT_HI, 16'h0000);
        final_report();
    end
endmodule : wakeup_timer_32bit_test
